/* File: hdl/pulse_width_and_delay_timer.sv */
`timescale 1ns/10ps
module pulse_width_and_delay_timer
  import pwd_timer_pkg::*;
#(
  parameter int unsigned CHANNEL_ID = 1
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire reg_req_t bus_i,
  input wire logic capture_input_pin_i,
  input wire logic serial_receive_input_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic channel_interrupt_o,
  output logic channel_enable_status_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam logic HAS_UPPER = (CHANNEL_ID == 1) || (CHANNEL_ID == 3);

  mode_ctrl_t mode_q;
  chan_state_t state_q;
  logic [15:0] data_q, count_q, prescale_q, div_q, rdata_q;
  logic ovf_q, ovf_pend_q, enable_q, upper_enable_q, irq_q;
  logic unit_en_q, lin_q, filt_en_q;
  logic samp_q, samp2_q, filt_q, filt_prev_q;

  logic [3:0] tick_k;
  logic tick, pin, rise, fall;
  logic is_width, is_delay, start_edge, capture_edge, delay_edge;
  logic launch_width, capture, delay_trig, delay_done;
  logic wr_ok, wr_cfg, start_wr, stop_wr, upper_wr;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Only the config register stays writable with the unit off
  assign wr_ok = bus_i.wr && unit_en_q;
  assign wr_cfg = bus_i.wr && (bus_i.addr == OFS_CONFIG);
  assign start_wr = wr_ok && (bus_i.addr == OFS_TRIGGER) && bus_i.wdata[TRG_START_BIT];
  assign stop_wr = wr_ok && (bus_i.addr == OFS_TRIGGER) && bus_i.wdata[TRG_STOP_BIT];
  assign upper_wr = wr_ok && (bus_i.addr == OFS_TRIGGER) && bus_i.wdata[TRG_UPPER_BIT];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      unit_en_q <= 1'b0;
      lin_q <= 1'b0;
      filt_en_q <= 1'b0;
    end else if (wr_cfg) begin
      unit_en_q <= bus_i.wdata[CFG_UNIT_EN_BIT];
      lin_q <= bus_i.wdata[CFG_LIN_BIT];
      filt_en_q <= bus_i.wdata[CFG_FILTER_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_q <= MODE_RST;
      prescale_q <= PRESCALE_RST;
    end else if (!unit_en_q) begin
      mode_q <= MODE_RST;
      prescale_q <= PRESCALE_RST;
    end else if (wr_ok && (bus_i.addr == OFS_MODE)) begin
      mode_q <= bus_i.wdata;
    end else if (wr_ok && (bus_i.addr == OFS_PRESCALE)) begin
      prescale_q <= bus_i.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and operating clock select
  // ----------------------------------------------------------------
  // Divider stops with the unit, standing in for the gated clock
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_q <= COUNT_ZERO;
    end else if (!unit_en_q) begin
      div_q <= COUNT_ZERO;
    end else begin
      div_q <= div_q + COUNT_ONE;
    end
  end

  generate
    for (genvar k = 0; k < 4; k++) begin : g_presc
      logic [15:0] mask;
      assign mask = (COUNT_ONE << prescale_q[k*PRESCALE_FIELD_W +: PRESCALE_FIELD_W]) - COUNT_ONE;
      assign tick_k[k] = unit_en_q && ((div_q & mask) == mask);
    end
  endgenerate

  // Clocks two and three fall back to clock zero on other channels
  always_comb begin
    case (mode_q.clk_sel)
      CKS_ZERO: tick = tick_k[0];
      CKS_ONE: tick = tick_k[1];
      CKS_TWO: tick = HAS_UPPER ? tick_k[2] : tick_k[0];
      default: tick = HAS_UPPER ? tick_k[3] : tick_k[0];
    endcase
  end

  // ----------------------------------------------------------------
  // Input path: route, sample, filter, edge detect
  // ----------------------------------------------------------------
  assign pin = lin_q ? serial_receive_input_i : capture_input_pin_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      samp_q <= 1'b0;
      samp2_q <= 1'b0;
      filt_q <= 1'b0;
      filt_prev_q <= 1'b0;
    end else if (!unit_en_q) begin
      samp_q <= 1'b0;
      samp2_q <= 1'b0;
      filt_q <= 1'b0;
      filt_prev_q <= 1'b0;
    end else if (tick) begin
      samp_q <= pin;
      samp2_q <= samp_q;
      filt_prev_q <= filt_q;
      // Filter needs two equal samples; costs one tick of latency
      if (!filt_en_q || (samp_q == samp2_q)) begin
        filt_q <= samp_q;
      end
    end
  end

  // Both edges share the same latency, so widths stay exact
  assign rise = tick && filt_q && !filt_prev_q;
  assign fall = tick && !filt_q && filt_prev_q;

  // ----------------------------------------------------------------
  // Mode decode and events
  // ----------------------------------------------------------------
  assign is_width = (mode_q.op_mode == MODE_WIDTH);
  assign is_delay = (mode_q.op_mode == MODE_DELAY);

  always_comb begin
    start_edge = 1'b0;
    capture_edge = 1'b0;
    if (mode_q.edge_sel == CIS_HIGH_WIDTH) begin
      start_edge = rise;
      capture_edge = fall;
    end else if (mode_q.edge_sel == CIS_LOW_WIDTH) begin
      start_edge = fall;
      capture_edge = rise;
    end
  end

  always_comb begin
    case (mode_q.edge_sel)
      CIS_FALL: delay_edge = fall;
      CIS_RISE: delay_edge = rise;
      default: delay_edge = rise || fall;
    endcase
  end

  assign launch_width = is_width && (state_q == ST_WAIT) && start_edge;
  assign capture = is_width && (state_q == ST_RUN) && capture_edge;
  assign delay_trig = is_delay && (state_q == ST_WAIT) && enable_q
                      && (delay_edge || start_wr);
  assign delay_done = is_delay && (state_q == ST_RUN) && tick && (count_q == COUNT_ZERO);

  // ----------------------------------------------------------------
  // Channel sequencing
  // ----------------------------------------------------------------
  // A start while enabled is simply ignored in width mode
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      enable_q <= 1'b0;
    end else if (!unit_en_q) begin
      state_q <= ST_IDLE;
      enable_q <= 1'b0;
    end else if (stop_wr) begin
      state_q <= ST_IDLE;
      enable_q <= 1'b0;
    end else if (start_wr && !enable_q) begin
      state_q <= ST_WAIT;
      enable_q <= 1'b1;
    end else begin
      case (state_q)
        ST_WAIT: begin
          if (launch_width || delay_trig) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (capture || delay_done) begin
            state_q <= ST_WAIT;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upper_enable_q <= 1'b0;
    end else if (!unit_en_q || stop_wr) begin
      upper_enable_q <= 1'b0;
    end else if (upper_wr && HAS_UPPER) begin
      upper_enable_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_q <= COUNT_ZERO;
    end else if (!unit_en_q) begin
      count_q <= COUNT_ZERO;
    end else if (stop_wr) begin
      count_q <= count_q;
    end else if (launch_width) begin
      count_q <= COUNT_ZERO;
    end else if (delay_trig) begin
      count_q <= data_q;
    end else if ((state_q == ST_RUN) && tick) begin
      if (is_width) begin
        // Wraps at all ones; capture tick leaves value plus one
        count_q <= count_q + COUNT_ONE;
      end else if (is_delay && (count_q != COUNT_ZERO)) begin
        count_q <= count_q - COUNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Overflow tracking
  // ----------------------------------------------------------------
  // Repeated wraps collapse into one flag; the width is then invalid
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_pend_q <= 1'b0;
    end else if (!unit_en_q || launch_width) begin
      ovf_pend_q <= 1'b0;
    end else if (is_width && (state_q == ST_RUN) && tick && !capture && !stop_wr
                 && (count_q == COUNT_MAX)) begin
      ovf_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_q <= 1'b0;
    end else if (!unit_en_q) begin
      ovf_q <= 1'b0;
    end else if (capture && !stop_wr) begin
      ovf_q <= ovf_pend_q;
    end
  end

  // ----------------------------------------------------------------
  // Data register and interrupt
  // ----------------------------------------------------------------
  // Capture wins over a software write in the same cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_q <= DATA_RST;
    end else if (!unit_en_q) begin
      data_q <= DATA_RST;
    end else if (capture && !stop_wr) begin
      data_q <= count_q;
    end else if (wr_ok && (bus_i.addr == OFS_DATA)) begin
      data_q <= bus_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= unit_en_q && !stop_wr && (capture || delay_done);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= COUNT_ZERO;
    end else if (!bus_i.rd) begin
      rdata_q <= COUNT_ZERO;
    end else if (bus_i.addr == OFS_MODE) begin
      rdata_q <= mode_q;
    end else if (bus_i.addr == OFS_DATA) begin
      rdata_q <= data_q;
    end else if (bus_i.addr == OFS_COUNT) begin
      rdata_q <= count_q;
    end else if (bus_i.addr == OFS_STATUS) begin
      rdata_q <= {15'h0000, ovf_q};
    end else if (bus_i.addr == OFS_ENABLE) begin
      rdata_q <= {14'h0000, upper_enable_q, enable_q};
    end else if (bus_i.addr == OFS_CONFIG) begin
      rdata_q <= {13'h0000, filt_en_q, lin_q, unit_en_q};
    end else if (bus_i.addr == OFS_PRESCALE) begin
      rdata_q <= prescale_q;
    end else begin
      rdata_q <= COUNT_ZERO;
    end
  end

  assign rdata_o = rdata_q;
  assign channel_interrupt_o = irq_q;
  assign channel_enable_status_o = enable_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_capture;
    capture && unit_en_q && !stop_wr;
  endsequence

  sequence s_delay_load;
    delay_trig && unit_en_q && !stop_wr;
  endsequence

  property p_capture_irq;
    s_capture |=> channel_interrupt_o && (data_q == $past(count_q));
  endproperty
  a_capture_irq: assert property (p_capture_irq)
    else $error("capture did not store count with interrupt");

  property p_halt_plus_one;
    s_capture |=> (count_q == data_q + COUNT_ONE) && (state_q == ST_WAIT);
  endproperty
  a_halt_plus_one: assert property (p_halt_plus_one)
    else $error("counter not halted at capture plus one");

  property p_ovf_update;
    s_capture |=> (ovf_q == $past(ovf_pend_q));
  endproperty
  a_ovf_update: assert property (p_ovf_update)
    else $error("overflow flag not updated at capture");

  property p_start_enable;
    start_wr && !enable_q && !stop_wr |=> enable_q && (state_q == ST_WAIT);
  endproperty
  a_start_enable: assert property (p_start_enable)
    else $error("start did not enable and arm");

  property p_stop_hold;
    stop_wr ##1 (unit_en_q && !start_wr) |-> $stable(count_q) && $stable(ovf_q) && !enable_q;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stop did not hold counter and flag");

  property p_delay_load;
    s_delay_load |=> (count_q == $past(data_q)) && (state_q == ST_RUN);
  endproperty
  a_delay_load: assert property (p_delay_load)
    else $error("delay trigger did not load data");

  property p_delay_done;
    delay_done && unit_en_q && !stop_wr |=> channel_interrupt_o && (state_q == ST_WAIT);
  endproperty
  a_delay_done: assert property (p_delay_done)
    else $error("zero reached without interrupt");

  property p_unit_off;
    !unit_en_q |=> (count_q == COUNT_ZERO) && !enable_q && (data_q == DATA_RST) && !ovf_q;
  endproperty
  a_unit_off: assert property (p_unit_off)
    else $error("unit disable did not clear channel");

  property p_launch_zero;
    launch_width && unit_en_q && !stop_wr |=> (count_q == COUNT_ZERO) && !ovf_pend_q;
  endproperty
  a_launch_zero: assert property (p_launch_zero)
    else $error("start edge did not clear counter");

  property p_wrap_flag;
    is_width && (state_q == ST_RUN) && tick && (count_q == COUNT_MAX) && !capture
      && !stop_wr && unit_en_q |=> ovf_pend_q && (count_q == COUNT_ZERO);
  endproperty
  a_wrap_flag: assert property (p_wrap_flag)
    else $error("wrap not recorded as overflow");

endmodule // pulse_width_and_delay_timer

/* File: hdl/pwd_timer_pkg.sv */
// Function
// - Width equals period times overflow-extended capture plus one
// - Input sampled on selected operating clock tick
// - Width mode counter counts up
// - Start trigger sets enable, waits start edge
// - Start edge clears counter, counts from zero
// - Capture edge stores counter, pulses interrupt
// - Overflow flag updated at every capture
// - Counter halts at capture plus one, rearms
// - Multiple wraps still only set overflow flag
// - Edge codes select low or high width
// - Clock select codes pick prescaled clocks
// - Stop clears enable, holds counter and flag
// - Unit disable resets channel, blocks writes
// - Delay interrupt after data plus one ticks
// - Delay mode counts down after trigger
// - Edge loads data, zero raises interrupt, stops
// - Start write while enabled acts as edge
// - New data value used from next period
// - Upper-half start sets upper-half enable status
// - Per-channel noise filter enable or bypass
package pwd_timer_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_DATA = 4'h1;
  localparam logic [3:0] OFS_COUNT = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  localparam logic [3:0] OFS_TRIGGER = 4'h4;
  localparam logic [3:0] OFS_ENABLE = 4'h5;
  localparam logic [3:0] OFS_CONFIG = 4'h6;
  localparam logic [3:0] OFS_PRESCALE = 4'h7;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int TRG_START_BIT = 0;
  localparam int TRG_STOP_BIT = 1;
  localparam int TRG_UPPER_BIT = 2;
  localparam int CFG_UNIT_EN_BIT = 0;
  localparam int CFG_LIN_BIT = 1;
  localparam int CFG_FILTER_BIT = 2;
  localparam int OVF_BIT = 0;
  localparam int PRESCALE_FIELD_W = 4;
  localparam logic [2:0] MODE_WIDTH = 3'h6;
  localparam logic [2:0] MODE_DELAY = 3'h4;
  localparam logic [1:0] CIS_FALL = 2'h0;
  localparam logic [1:0] CIS_RISE = 2'h1;
  localparam logic [1:0] CIS_LOW_WIDTH = 2'h2;
  localparam logic [1:0] CIS_HIGH_WIDTH = 2'h3;
  localparam logic [1:0] CKS_ZERO = 2'h0;
  localparam logic [1:0] CKS_ONE = 2'h2;
  localparam logic [1:0] CKS_TWO = 2'h1;
  localparam logic [1:0] CKS_THREE = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] PRESCALE_RST = 16'h0000;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] clk_sel;
    logic [5:0] rsv_hi;
    logic [1:0] edge_sel;
    logic [1:0] rsv_lo;
    logic [2:0] op_mode;
    logic start_irq_opt;
  } mode_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} chan_state_t;

endpackage

/* File: tb/pin_source.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Level source for one timer input line
// ----------------------------------------
module pin_source (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic go_i,
  input wire logic idle_i,
  input wire logic [16:0] width_i,
  output logic pin_o
);
  logic [16:0] left_q;

  // Pulse opens the cycle after go and lasts width cycles; go while busy is dropped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      left_q <= 17'h00000;
    end else if (go_i && left_q == 17'h00000) begin
      left_q <= width_i;
    end else if (left_q != 17'h00000) begin
      left_q <= left_q - 17'h00001;
    end
  end

  // Idle level is chosen by the caller, so low and high widths both reachable
  assign pin_o = (left_q != 17'h00000) ? ~idle_i : idle_i;
endmodule // pin_source

/* File: tb/test_pulse_width_and_delay_timer.sv */
`timescale 1ns/10ps
module test_pulse_width_and_delay_timer;
  import pwd_timer_pkg::*;
  logic clk_i;
  logic nrst_i;
  reg_req_t bus;
  logic pin_go, rx_go, pin_idle, rx_idle, pin, rx, irq, en;
  logic [16:0] pw;
  logic [DATA_W-1:0] rdata_o;
  int fail_count;
  int checks_done;

  pulse_width_and_delay_timer #(.CHANNEL_ID(1)) u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .bus_i(bus), .capture_input_pin_i(pin),
    .serial_receive_input_i(rx), .rdata_o(rdata_o), .channel_interrupt_o(irq),
    .channel_enable_status_o(en));
  pin_source u_pin (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(pin_go), .idle_i(pin_idle),
    .width_i(pw), .pin_o(pin));
  pin_source u_rx (.clk_i(clk_i), .nrst_i(nrst_i), .go_i(rx_go), .idle_i(rx_idle),
    .width_i(pw), .pin_o(rx));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask

  // Read data stands only in the cycle after the read edge
  task automatic rc(input string what, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_i);
    bus <= '0;
    #1;
    check(what, exp, rdata_o);
  endtask

  // Interrupt is a one-cycle pulse, so every cycle is polled
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask

  task automatic pulse(input logic on_rx, input logic [16:0] w);
    @(posedge clk_i);
    pw <= w;
    if (on_rx) rx_go <= 1'b1;
    else pin_go <= 1'b1;
    @(posedge clk_i);
    rx_go <= 1'b0;
    pin_go <= 1'b0;
  endtask

  task automatic measure(input logic on_rx, input logic [16:0] w, input logic [15:0] ovf);
    int n;
    pulse(on_rx, w);
    wait_irq(int'(w) + 20, n);
    check("irq", 16'h0001, {15'h0000, irq});
    rc("data", OFS_DATA, w[15:0] - 16'h0001);
    rc("ovf", OFS_STATUS, ovf);
    rc("count", OFS_COUNT, w[15:0]);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rc("mode_rst", OFS_MODE, MODE_RST);
    rc("enable_rst", OFS_ENABLE, 16'h0000);
    wr(OFS_DATA, 16'h1234);
    rc("data_blocked", OFS_DATA, DATA_RST);
    wr(OFS_CONFIG, 16'h0001);
    wr(OFS_DATA, 16'h1234);
    rc("data_rw", OFS_DATA, 16'h1234);
    rc("trigger_rd", OFS_TRIGGER, 16'h0000);
    rc("unmapped", 4'hF, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_width;
    wr(OFS_PRESCALE, 16'h0000);
    wr(OFS_MODE, 16'h00CC);
    wr(OFS_TRIGGER, 16'h0001);
    rc("enable", OFS_ENABLE, 16'h0001);
    check("en_pin", 16'h0001, {15'h0000, en});
    measure(1'b0, 17'h00014, 16'h0000);
    measure(1'b0, 17'h00005, 16'h0000);
    measure(1'b0, 17'h1000A, 16'h0001);
    $display("test width done");
  endtask

  task automatic t_stop;
    logic [15:0] a;
    pulse(1'b0, 17'h00028);
    repeat (10) @(posedge clk_i);
    wr(OFS_TRIGGER, 16'h0002);
    rc("enable_stop", OFS_ENABLE, 16'h0000);
    check("en_pin_stop", 16'h0000, {15'h0000, en});
    @(posedge clk_i);
    bus <= {OFS_COUNT, 16'h0000, 1'b0, 1'b1};
    @(posedge clk_i);
    bus <= '0;
    #1;
    a = rdata_o;
    check("count_ran", 16'h0001, {15'h0000, a != 16'h0000});
    repeat (5) @(posedge clk_i);
    rc("count_hold", OFS_COUNT, a);
    rc("ovf_hold", OFS_STATUS, 16'h0001);
    repeat (40) @(posedge clk_i);
    $display("test stop done");
  endtask

  task automatic t_low;
    @(posedge clk_i);
    pin_idle <= 1'b1;
    repeat (5) @(posedge clk_i);
    wr(OFS_MODE, 16'h008C);
    wr(OFS_TRIGGER, 16'h0001);
    measure(1'b0, 17'h00007, 16'h0000);
    $display("test low done");
  endtask

  task automatic t_lin;
    int n;
    wr(OFS_TRIGGER, 16'h0002);
    wr(OFS_MODE, 16'h00CC);
    wr(OFS_CONFIG, 16'h0007);
    wr(OFS_TRIGGER, 16'h0001);
    pulse(1'b1, 17'h00001);
    wait_irq(12, n);
    check("glitch", 16'h0000, {15'h0000, irq});
    measure(1'b1, 17'h00009, 16'h0000);
    $display("test lin done");
  endtask

  task automatic t_delay;
    int na, nb, n;
    wr(OFS_TRIGGER, 16'h0002);
    wr(OFS_CONFIG, 16'h0001);
    wr(OFS_PRESCALE, 16'h0003);
    wr(OFS_DATA, 16'h0003);
    wr(OFS_MODE, 16'h8048);
    wr(OFS_TRIGGER, 16'h0005);
    rc("enable_both", OFS_ENABLE, 16'h0003);
    wr(OFS_TRIGGER, 16'h0001);
    wr(OFS_DATA, 16'h0007);
    wait_irq(100, na);
    check("irq_a", 16'h0001, {15'h0000, irq});
    rc("count_zero", OFS_COUNT, 16'h0000);
    wr(OFS_TRIGGER, 16'h0001);
    wr(OFS_DATA, 16'h0007);
    wait_irq(100, nb);
    check("irq_b", 16'h0001, {15'h0000, irq});
    check("delay_step", 16'h0004, 16'(nb - na));
    @(posedge clk_i);
    pin_idle <= 1'b0;
    wait_irq(20, n);
    check("fall_ignored", 16'h0000, {15'h0000, irq});
    pulse(1'b0, 17'h00003);
    wait_irq(40, n);
    check("edge_irq", 16'h0001, {15'h0000, irq});
    // Clock zero ticks every eight cycles; divider phase unknown, so a window
    wr(OFS_MODE, 16'h0048);
    wr(OFS_TRIGGER, 16'h0001);
    wait_irq(80, n);
    check("slow_tick", 16'h0001, {15'h0000, irq && n >= 57 && n <= 64});
    $display("test delay done");
  endtask

  task automatic t_off;
    wr(OFS_CONFIG, 16'h0000);
    rc("enable_off", OFS_ENABLE, 16'h0000);
    check("en_pin_off", 16'h0000, {15'h0000, en});
    rc("data_off", OFS_DATA, DATA_RST);
    rc("mode_off", OFS_MODE, MODE_RST);
    $display("test off done");
  endtask

  initial begin
    bus = '0;
    pin_go = 1'b0;
    rx_go = 1'b0;
    pin_idle = 1'b0;
    rx_idle = 1'b0;
    pw = 17'h00000;
    fail_count = 0;
    checks_done = 0;
    nrst_i = 1'b0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs;
    t_width;
    t_stop;
    t_low;
    t_lin;
    t_delay;
    t_off;
    print_verdict;
  end

  // Overflow run alone needs about 66k cycles
  initial begin
    repeat (90000) @(posedge clk_i);
    fail_count++;
    print_verdict;
  end
endmodule // test_pulse_width_and_delay_timer
